// file: plc_pkg.sv
package plc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register offsets, one word each
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_IRON_WATT = 8'h04;
  localparam logic [7:0] OFS_COPPER_WATT = 8'h08;
  localparam logic [7:0] OFS_IRON_VAR = 8'h0C;
  localparam logic [7:0] OFS_COPPER_VAR = 8'h10;
  localparam logic [7:0] OFS_FS_VA = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_WATT_LOSS = 8'h1C;
  localparam logic [7:0] OFS_VAR_LOSS = 8'h20;
  // control fields
  localparam int CTRL_IRON_EN = 0;
  localparam int CTRL_COPPER_EN = 1;
  localparam int CTRL_ADD = 2;
  localparam int CTRL_DIR_INV = 3;
  localparam int CTRL_TWO_ELEM = 4;
  localparam int CTRL_TEST = 5;
  localparam int CTRL_W = 6;
  localparam logic [5:0] CTRL_RST = 6'h04;
  localparam logic [15:0] PCT_RST = 16'h0000;
  localparam logic [15:0] FS_VA_RST = 16'h0258;
  // status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_PHASE_LO = 1;
  localparam int STAT_CNT_LO = 16;
  // number scaling: volts in 1/128 V, amps in 1/4096 A
  localparam int VOLT_LSB_PER_V = 128;
  localparam int AMP_LSB_PER_A = 4096;
  localparam int BASE_VOLT_V = 120;
  localparam int BASE_AMP_A = 5;
  localparam int RATIO_FRAC = 14;
  localparam int PCT_FRAC = 16;
  localparam int RECIP_SHIFT = 30;
  localparam int RECIP_BASE_I = (2 ** RECIP_SHIFT) / (BASE_AMP_A * AMP_LSB_PER_A);
  localparam logic [1:0] LAST_PHASE = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RATIO = 3'b001,
    ST_POWER = 3'b010,
    ST_TERM = 3'b011,
    ST_LOSS = 3'b100,
    ST_APPLY = 3'b101
  } state_type;

  typedef struct packed {
    logic [1:0] phase;
    logic [15:0] volt_ln;
    logic [15:0] volt_ll;
    logic [15:0] amps;
    logic signed [31:0] watt;
    logic signed [31:0] vars;
  } meas_type;

  typedef struct packed {
    logic [1:0] phase;
    logic signed [31:0] watt;
    logic signed [31:0] vars;
    logic [31:0] watt_loss;
    logic [31:0] var_loss;
  } comp_type;

  typedef struct packed {
    logic [5:0] ctrl;
    logic [15:0] iron_watt_loss_pct;
    logic [15:0] copper_watt_loss_pct;
    logic [15:0] iron_var_loss_pct;
    logic [15:0] copper_var_loss_pct;
    logic [15:0] fs_va;
  } cfg_type;
endpackage

// file: power_loss_compensator.sv
// The placing of the registers and the address-and-strobe port were left to the implementer.
module power_loss_compensator #(
  parameter int BASE_VOLT_LL_V = 120
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // register port
  input wire logic [plc_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [plc_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [plc_pkg::DATA_W-1:0] REG_RDATA,
  // measurement in
  input wire logic MEAS_VALID,
  input wire plc_pkg::meas_type MEAS,
  output logic MEAS_READY,
  // compensated out
  output logic COMP_VALID,
  output plc_pkg::comp_type COMP,
  output logic TOTAL_VALID,
  output logic signed [31:0] TOTAL_WATT,
  output logic signed [31:0] TOTAL_VAR
);
  localparam int RECIP_V_LN = (2 ** plc_pkg::RECIP_SHIFT) / (plc_pkg::BASE_VOLT_V * plc_pkg::VOLT_LSB_PER_V);
  localparam int RECIP_V_LL = (2 ** plc_pkg::RECIP_SHIFT) / (BASE_VOLT_LL_V * plc_pkg::VOLT_LSB_PER_V);
  localparam int RSH = plc_pkg::RECIP_SHIFT - plc_pkg::RATIO_FRAC;

  // software-facing shadow settings
  plc_pkg::cfg_type shadow_r, shadow_nxt;
  // settings used by the running calculation
  plc_pkg::cfg_type cfg_r, cfg_nxt;
  logic [plc_pkg::DATA_W-1:0] rdata_r, rdata_nxt;

  plc_pkg::state_type state_r, state_nxt;
  plc_pkg::meas_type meas_r, meas_nxt;
  logic [31:0] vr_r, vr_nxt, ir_r, ir_nxt;
  logic [31:0] vr2_r, vr2_nxt, ir2_r, ir2_nxt;
  logic [31:0] vr4_r, vr4_nxt, wsum_r, wsum_nxt;
  logic [31:0] wloss_r, wloss_nxt, vloss_r, vloss_nxt;
  plc_pkg::comp_type comp_r, comp_nxt;
  logic comp_valid_r, comp_valid_nxt;
  logic ready_r, ready_nxt;
  logic signed [31:0] acc_w_r, acc_w_nxt, acc_v_r, acc_v_nxt;
  logic signed [31:0] tot_w_r, tot_w_nxt, tot_v_r, tot_v_nxt;
  logic tot_valid_r, tot_valid_nxt;
  logic [15:0] count_r, count_nxt;

  logic take;
  logic [63:0] p_a, p_b, p_c;
  logic [15:0] volt_sel;
  logic [31:0] recip_v;
  logic signed [31:0] sw, sv;
  logic plus;

  assign take = MEAS_VALID && ready_r;

  // register file
  always_comb begin
    shadow_nxt = shadow_r;
    rdata_nxt = 32'h0000_0000;
    if (REG_WR) begin
      case (REG_ADDR)
        plc_pkg::OFS_CTRL: shadow_nxt.ctrl = REG_WDATA[plc_pkg::CTRL_W-1:0];
        plc_pkg::OFS_IRON_WATT: shadow_nxt.iron_watt_loss_pct = REG_WDATA[15:0];
        plc_pkg::OFS_COPPER_WATT: shadow_nxt.copper_watt_loss_pct = REG_WDATA[15:0];
        plc_pkg::OFS_IRON_VAR: shadow_nxt.iron_var_loss_pct = REG_WDATA[15:0];
        plc_pkg::OFS_COPPER_VAR: shadow_nxt.copper_var_loss_pct = REG_WDATA[15:0];
        plc_pkg::OFS_FS_VA: shadow_nxt.fs_va = REG_WDATA[15:0];
        default: shadow_nxt = shadow_r;
      endcase
    end
    if (REG_RD) begin
      case (REG_ADDR)
        plc_pkg::OFS_CTRL: rdata_nxt[plc_pkg::CTRL_W-1:0] = shadow_r.ctrl;
        plc_pkg::OFS_IRON_WATT: rdata_nxt[15:0] = shadow_r.iron_watt_loss_pct;
        plc_pkg::OFS_COPPER_WATT: rdata_nxt[15:0] = shadow_r.copper_watt_loss_pct;
        plc_pkg::OFS_IRON_VAR: rdata_nxt[15:0] = shadow_r.iron_var_loss_pct;
        plc_pkg::OFS_COPPER_VAR: rdata_nxt[15:0] = shadow_r.copper_var_loss_pct;
        plc_pkg::OFS_FS_VA: rdata_nxt[15:0] = shadow_r.fs_va;
        plc_pkg::OFS_STATUS: begin
          rdata_nxt[plc_pkg::STAT_BUSY] = !ready_r;
          rdata_nxt[plc_pkg::STAT_PHASE_LO +: 2] = meas_r.phase;
          rdata_nxt[plc_pkg::STAT_CNT_LO +: 16] = count_r;
        end
        plc_pkg::OFS_WATT_LOSS: rdata_nxt = comp_r.watt_loss;
        plc_pkg::OFS_VAR_LOSS: rdata_nxt = comp_r.var_loss;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      shadow_r <= '{plc_pkg::CTRL_RST, plc_pkg::PCT_RST, plc_pkg::PCT_RST,
                    plc_pkg::PCT_RST, plc_pkg::PCT_RST, plc_pkg::FS_VA_RST};
      rdata_r <= 32'h0000_0000;
    end else begin
      shadow_r <= shadow_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // calculation sequencer; one phase reading at a time
  always_comb begin
    state_nxt = state_r;
    cfg_nxt = cfg_r;
    meas_nxt = meas_r;
    vr_nxt = vr_r;
    ir_nxt = ir_r;
    vr2_nxt = vr2_r;
    ir2_nxt = ir2_r;
    vr4_nxt = vr4_r;
    wsum_nxt = wsum_r;
    wloss_nxt = wloss_r;
    vloss_nxt = vloss_r;
    comp_nxt = comp_r;
    comp_valid_nxt = 1'b0;
    acc_w_nxt = acc_w_r;
    acc_v_nxt = acc_v_r;
    tot_w_nxt = tot_w_r;
    tot_v_nxt = tot_v_r;
    tot_valid_nxt = 1'b0;
    count_nxt = count_r;
    volt_sel = cfg_r.ctrl[plc_pkg::CTRL_TWO_ELEM] ? meas_r.volt_ll : meas_r.volt_ln;
    recip_v = cfg_r.ctrl[plc_pkg::CTRL_TWO_ELEM] ? 32'(RECIP_V_LL) : 32'(RECIP_V_LN);
    p_a = 64'h0000_0000_0000_0000;
    p_b = 64'h0000_0000_0000_0000;
    p_c = 64'h0000_0000_0000_0000;
    plus = cfg_r.ctrl[plc_pkg::CTRL_ADD] ^ cfg_r.ctrl[plc_pkg::CTRL_DIR_INV];
    sw = plus ? $signed(wloss_r) : -$signed(wloss_r);
    sv = plus ? $signed(vloss_r) : -$signed(vloss_r);
    case (state_r)
      plc_pkg::ST_IDLE: begin
        // settings only move while nothing is in flight
        cfg_nxt = shadow_r;
        if (take) begin
          meas_nxt = MEAS;
          state_nxt = plc_pkg::ST_RATIO;
        end
      end
      plc_pkg::ST_RATIO: begin
        p_a = 64'(volt_sel) * 64'(recip_v);
        p_b = 64'(meas_r.amps) * 64'(plc_pkg::RECIP_BASE_I);
        vr_nxt = 32'(p_a >> RSH);
        ir_nxt = 32'(p_b >> RSH);
        state_nxt = plc_pkg::ST_POWER;
      end
      plc_pkg::ST_POWER: begin
        p_a = 64'(vr_r) * 64'(vr_r);
        p_b = 64'(ir_r) * 64'(ir_r);
        vr2_nxt = 32'(p_a >> plc_pkg::RATIO_FRAC);
        ir2_nxt = 32'(p_b >> plc_pkg::RATIO_FRAC);
        state_nxt = plc_pkg::ST_TERM;
      end
      plc_pkg::ST_TERM: begin
        p_a = 64'(vr2_r) * 64'(vr2_r);
        vr4_nxt = 32'(p_a >> plc_pkg::RATIO_FRAC);
        p_b = cfg_r.ctrl[plc_pkg::CTRL_IRON_EN] ? 64'(vr2_r) * 64'(cfg_r.iron_watt_loss_pct) : 64'h0;
        p_c = cfg_r.ctrl[plc_pkg::CTRL_COPPER_EN] ? 64'(ir2_r) * 64'(cfg_r.copper_watt_loss_pct) : 64'h0;
        wsum_nxt = 32'((p_b + p_c) >> plc_pkg::PCT_FRAC);
        state_nxt = plc_pkg::ST_LOSS;
      end
      plc_pkg::ST_LOSS: begin
        p_b = cfg_r.ctrl[plc_pkg::CTRL_IRON_EN] ? 64'(vr4_r) * 64'(cfg_r.iron_var_loss_pct) : 64'h0;
        p_c = cfg_r.ctrl[plc_pkg::CTRL_COPPER_EN] ? 64'(ir2_r) * 64'(cfg_r.copper_var_loss_pct) : 64'h0;
        p_a = ((p_b + p_c) >> plc_pkg::PCT_FRAC) * 64'(cfg_r.fs_va);
        vloss_nxt = 32'(p_a >> plc_pkg::RATIO_FRAC);
        p_a = 64'(wsum_r) * 64'(cfg_r.fs_va);
        wloss_nxt = 32'(p_a >> plc_pkg::RATIO_FRAC);
        if (cfg_r.ctrl[plc_pkg::CTRL_TEST]) begin
          wloss_nxt = 32'h0000_0000;
          vloss_nxt = 32'h0000_0000;
        end
        state_nxt = plc_pkg::ST_APPLY;
      end
      plc_pkg::ST_APPLY: begin
        // wrap on overflow is accepted; losses are far below full scale
        comp_nxt.phase = meas_r.phase;
        comp_nxt.watt = meas_r.watt + sw;
        comp_nxt.vars = meas_r.vars + sv;
        comp_nxt.watt_loss = wloss_r;
        comp_nxt.var_loss = vloss_r;
        comp_valid_nxt = 1'b1;
        count_nxt = count_r + 16'h0001;
        // totals are built only from compensated phases
        acc_w_nxt = (meas_r.phase == 2'h0) ? meas_r.watt + sw : acc_w_r + meas_r.watt + sw;
        acc_v_nxt = (meas_r.phase == 2'h0) ? meas_r.vars + sv : acc_v_r + meas_r.vars + sv;
        if (meas_r.phase == plc_pkg::LAST_PHASE) begin
          tot_w_nxt = acc_w_nxt;
          tot_v_nxt = acc_v_nxt;
          tot_valid_nxt = 1'b1;
        end
        state_nxt = plc_pkg::ST_IDLE;
      end
      default: state_nxt = plc_pkg::ST_IDLE;
    endcase
    ready_nxt = (state_nxt == plc_pkg::ST_IDLE);
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      state_r <= plc_pkg::ST_IDLE;
      cfg_r <= '{plc_pkg::CTRL_RST, plc_pkg::PCT_RST, plc_pkg::PCT_RST,
                 plc_pkg::PCT_RST, plc_pkg::PCT_RST, plc_pkg::FS_VA_RST};
      meas_r <= '0;
      vr_r <= 32'h0000_0000;
      ir_r <= 32'h0000_0000;
      vr2_r <= 32'h0000_0000;
      ir2_r <= 32'h0000_0000;
      vr4_r <= 32'h0000_0000;
      wsum_r <= 32'h0000_0000;
      wloss_r <= 32'h0000_0000;
      vloss_r <= 32'h0000_0000;
      comp_r <= '0;
      comp_valid_r <= 1'b0;
      ready_r <= 1'b0;
      acc_w_r <= 32'sh0000_0000;
      acc_v_r <= 32'sh0000_0000;
      tot_w_r <= 32'sh0000_0000;
      tot_v_r <= 32'sh0000_0000;
      tot_valid_r <= 1'b0;
      count_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      cfg_r <= cfg_nxt;
      meas_r <= meas_nxt;
      vr_r <= vr_nxt;
      ir_r <= ir_nxt;
      vr2_r <= vr2_nxt;
      ir2_r <= ir2_nxt;
      vr4_r <= vr4_nxt;
      wsum_r <= wsum_nxt;
      wloss_r <= wloss_nxt;
      vloss_r <= vloss_nxt;
      comp_r <= comp_nxt;
      comp_valid_r <= comp_valid_nxt;
      ready_r <= ready_nxt;
      acc_w_r <= acc_w_nxt;
      acc_v_r <= acc_v_nxt;
      tot_w_r <= tot_w_nxt;
      tot_v_r <= tot_v_nxt;
      tot_valid_r <= tot_valid_nxt;
      count_r <= count_nxt;
    end
  end

  assign REG_RDATA = rdata_r;
  assign MEAS_READY = ready_r;
  assign COMP_VALID = comp_valid_r;
  assign COMP = comp_r;
  assign TOTAL_VALID = tot_valid_r;
  assign TOTAL_WATT = tot_w_r;
  assign TOTAL_VAR = tot_v_r;

  sequence s_taken;
    MEAS_VALID && MEAS_READY;
  endsequence

  sequence s_busy5;
    !MEAS_READY [*5];
  endsequence

  property p_one_result;
    @(posedge CORE_CLK) disable iff (!RESETN)
      s_taken |=> s_busy5 ##1 (COMP_VALID && MEAS_READY);
  endproperty
  a_one_result: assert property (p_one_result) else $error("result not 6 cycles after take");

  property p_phase_kept;
    @(posedge CORE_CLK) disable iff (!RESETN)
      s_taken |-> ##6 (COMP.phase == $past(MEAS.phase, 6));
  endproperty
  a_phase_kept: assert property (p_phase_kept) else $error("phase tag lost");

  property p_cfg_frozen;
    @(posedge CORE_CLK) disable iff (!RESETN)
      (state_r != plc_pkg::ST_IDLE) && (state_nxt != plc_pkg::ST_IDLE) |=> $stable(cfg_r);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen) else $error("settings changed mid calculation");

  property p_test_bypass;
    @(posedge CORE_CLK) disable iff (!RESETN)
      COMP_VALID && cfg_r.ctrl[plc_pkg::CTRL_TEST] |-> (COMP.watt == meas_r.watt) && (COMP.vars == meas_r.vars);
  endproperty
  a_test_bypass: assert property (p_test_bypass) else $error("test mode altered reading");

  property p_no_enable_no_loss;
    @(posedge CORE_CLK) disable iff (!RESETN)
      COMP_VALID && !cfg_r.ctrl[plc_pkg::CTRL_IRON_EN] && !cfg_r.ctrl[plc_pkg::CTRL_COPPER_EN]
        |-> (COMP.watt_loss == 32'h0000_0000) && (COMP.var_loss == 32'h0000_0000);
  endproperty
  a_no_enable_no_loss: assert property (p_no_enable_no_loss) else $error("loss with both disabled");

  property p_direction;
    @(posedge CORE_CLK) disable iff (!RESETN)
      COMP_VALID |-> (COMP.watt == ((cfg_r.ctrl[plc_pkg::CTRL_ADD] ^ cfg_r.ctrl[plc_pkg::CTRL_DIR_INV])
        ? meas_r.watt + $signed(COMP.watt_loss) : meas_r.watt - $signed(COMP.watt_loss)));
  endproperty
  a_direction: assert property (p_direction) else $error("loss applied with wrong sign");

  property p_total;
    @(posedge CORE_CLK) disable iff (!RESETN)
      COMP_VALID |-> (TOTAL_VALID == (COMP.phase == plc_pkg::LAST_PHASE));
  endproperty
  a_total: assert property (p_total) else $error("total not with last phase");

  property p_ctrl_read;
    @(posedge CORE_CLK) disable iff (!RESETN)
      REG_RD && (REG_ADDR == plc_pkg::OFS_CTRL) |=> (REG_RDATA[plc_pkg::CTRL_W-1:0] == $past(shadow_r.ctrl));
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");
endmodule // power_loss_compensator

// file: plc_meas_src.sv
module plc_meas_src (
  // clock
  input wire logic clk,
  // measurement handshake
  output logic meas_valid,
  output plc_pkg::meas_type meas,
  input wire logic meas_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap = 0;

  initial begin
    meas_valid = 1'b0;
    meas = '0;
  end

  // released lines carry the inverse, so stale data never looks valid
  task automatic release_lines;
    meas_valid <= 1'b0;
    meas <= ~meas;
  endtask

  // holds the offer until the edge that takes it; gap makes a slow source
  task automatic offer(input plc_pkg::meas_type m);
    if (gap > 0) begin
      release_lines();
      repeat (gap) @(posedge clk);
    end
    meas_valid <= 1'b1;
    meas <= m;
    do @(posedge clk); while (meas_ready !== 1'b1);
  endtask
endmodule // plc_meas_src

// file: tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LL_V = 240;
  localparam int TOL = 8;
  logic CORE_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic [plc_pkg::ADDR_W-1:0] REG_ADDR = '0;
  logic [plc_pkg::DATA_W-1:0] REG_WDATA = '0;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [plc_pkg::DATA_W-1:0] REG_RDATA;
  logic MEAS_VALID;
  logic MEAS_READY;
  logic COMP_VALID;
  logic TOTAL_VALID;
  plc_pkg::meas_type MEAS;
  plc_pkg::comp_type COMP;
  logic signed [31:0] TOTAL_WATT;
  logic signed [31:0] TOTAL_VAR;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  int take_t = 0;
  logic [5:0] ctrl = 6'h04;
  logic [15:0] pct [4];
  logic [15:0] fs = 16'h0258;
  // last entry runs with both enables off so the no-loss check has something to see
  logic [5:0] modes [9] = '{6'h03, 6'h07, 6'h0F, 6'h0B, 6'h05, 6'h06, 6'h17, 6'h27, 6'h0C};
  plc_pkg::comp_type exp_q [$];
  plc_pkg::comp_type mon_c;
  longint tot_q [$];
  longint tw;
  longint tv;

  always #12.5 CORE_CLK = ~CORE_CLK;

  power_loss_compensator #(.BASE_VOLT_LL_V(LL_V)) u_dut (
    .CORE_CLK(CORE_CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .MEAS_VALID(MEAS_VALID),
    .MEAS(MEAS), .MEAS_READY(MEAS_READY), .COMP_VALID(COMP_VALID), .COMP(COMP),
    .TOTAL_VALID(TOTAL_VALID), .TOTAL_WATT(TOTAL_WATT), .TOTAL_VAR(TOTAL_VAR)
  );

  plc_meas_src u_src (.clk(CORE_CLK), .meas_valid(MEAS_VALID), .meas(MEAS), .meas_ready(MEAS_READY));

  task automatic chk(input string what, input logic signed [63:0] e, input logic signed [63:0] got,
                     input int tol = 0);
    n_compared++;
    if ($isunknown(got) || got > e + tol || got < e - tol) begin
      miscompares++;
      $display("FAIL %s expected %0d seen %0d", what, e, got);
    end
  endtask

  task automatic final_report;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e, input string w);
    @(posedge CORE_CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    @(negedge CORE_CLK);
    chk(w, e, REG_RDATA);
  endtask

  function automatic longint rat(longint v, longint lsb, longint base);
    return (v * ((longint'(1) << 30) / (base * lsb))) >>> 16;
  endfunction

  function automatic plc_pkg::comp_type predict(input plc_pkg::meas_type m);
    longint rv, ri, v2, i2, wl, vl;
    plc_pkg::comp_type c;
    rv = ctrl[4] ? rat(m.volt_ll, plc_pkg::VOLT_LSB_PER_V, LL_V)
                 : rat(m.volt_ln, plc_pkg::VOLT_LSB_PER_V, plc_pkg::BASE_VOLT_V);
    ri = rat(m.amps, plc_pkg::AMP_LSB_PER_A, plc_pkg::BASE_AMP_A);
    v2 = (rv * rv) >>> 14;
    i2 = (ri * ri) >>> 14;
    wl = ((v2 * pct[0] * ctrl[0] + i2 * pct[1] * ctrl[1]) >>> 16) * fs >>> 14;
    vl = ((((v2 * v2) >>> 14) * pct[2] * ctrl[0] + i2 * pct[3] * ctrl[1]) >>> 16) * fs >>> 14;
    if (ctrl[5]) begin
      wl = 0;
      vl = 0;
    end
    c.phase = m.phase;
    c.watt_loss = 32'(wl);
    c.var_loss = 32'(vl);
    c.watt = (ctrl[2] ^ ctrl[3]) ? 32'(m.watt + wl) : 32'(m.watt - wl);
    c.vars = (ctrl[2] ^ ctrl[3]) ? 32'(m.vars + vl) : 32'(m.vars - vl);
    return c;
  endfunction

  task automatic send(input int p);
    plc_pkg::meas_type m;
    plc_pkg::comp_type c;
    m.phase = 2'(p);
    m.volt_ln = 16'(15360 - p * 3000);
    m.volt_ll = 16'(30720 - p * 2000);
    m.amps = 16'(20480 - p * 6000);
    m.watt = (p == 1) ? -32'sd2000000 : 32'(2000000 + p);
    m.vars = 32'(500000 * (1 - p));
    c = predict(m);
    if (p == 0) begin
      tw = 0;
      tv = 0;
    end
    tw += c.watt;
    tv += c.vars;
    if (p == 2) begin
      tot_q.push_back(tw);
      tot_q.push_back(tv);
    end
    exp_q.push_back(c);
    u_src.offer(m);
  endtask

  task automatic drain;
    u_src.release_lines();
    while (exp_q.size() != 0) @(posedge CORE_CLK);
  endtask

  always @(posedge CORE_CLK) begin
    if (RESETN) begin
      if (COMP_VALID === 1'b1) begin
        chk("pending", 1, exp_q.size() > 0);
        mon_c = exp_q.pop_front();
        chk("latency", 6, cyc - take_t);
        chk("phase", mon_c.phase, COMP.phase);
        chk("watt", mon_c.watt, COMP.watt, TOL);
        chk("vars", mon_c.vars, COMP.vars, TOL);
        chk("watt loss", mon_c.watt_loss, COMP.watt_loss, TOL);
        chk("var loss", mon_c.var_loss, COMP.var_loss, TOL);
        chk("total valid", mon_c.phase == 2'h2, TOTAL_VALID);
        if (mon_c.phase == 2'h2) begin
          chk("total watt", tot_q.pop_front(), TOTAL_WATT, 3 * TOL);
          chk("total var", tot_q.pop_front(), TOTAL_VAR, 3 * TOL);
        end
      end
      if (MEAS_VALID === 1'b1 && MEAS_READY === 1'b1) take_t = cyc;
      cyc++;
    end
  end

  initial begin
    repeat (5000) @(posedge CORE_CLK);
    miscompares++;
    final_report();
  end

  initial begin
    pct = '{default: 16'h0000};
    repeat (16) @(posedge CORE_CLK);
    RESETN <= 1'b1;
    @(posedge CORE_CLK);
    reg_rd(plc_pkg::OFS_CTRL, 32'h0000_0004, "ctrl reset");
    reg_rd(plc_pkg::OFS_FS_VA, 32'h0000_0258, "full scale reset");
    reg_rd(plc_pkg::OFS_COPPER_VAR, 32'h0000_0000, "pct reset");
    reg_wr(8'h24, 32'hFFFF_FFFF);
    reg_rd(8'h24, 32'h0000_0000, "unmapped");
    reg_rd(plc_pkg::OFS_CTRL, 32'h0000_0004, "ctrl after unmapped write");
    for (int i = 0; i < 4; i++) begin
      pct[i] = 16'(16'h1000 * (i + 1));
      reg_wr(8'(plc_pkg::OFS_IRON_WATT + 4 * i), 32'(pct[i]));
      reg_rd(8'(plc_pkg::OFS_IRON_WATT + 4 * i), 32'(pct[i]), "pct readback");
    end
    fs = 16'h4000;
    reg_wr(plc_pkg::OFS_FS_VA, 32'(fs));
    // add/sub, flow direction, single enables, two-element, test mode
    foreach (modes[k]) begin
      ctrl = modes[k];
      reg_wr(plc_pkg::OFS_CTRL, 32'(ctrl));
      // the fifth mode (6'h05) is fed by a slow source, 3 idle cycles before each offer
      u_src.gap = (k == 4) ? 3 : 0;
      for (int p = 0; p < 3; p++) send(p);
      drain();
    end
    ctrl = 6'h07;
    reg_wr(plc_pkg::OFS_CTRL, 32'(ctrl));
    // a write landing mid-calculation must not touch that result
    fork
      send(0);
      begin
        repeat (3) @(posedge CORE_CLK);
        reg_wr(plc_pkg::OFS_CTRL, 32'h0000_0027);
      end
    join
    ctrl = 6'h27;
    drain();
    send(0);
    drain();
    reg_rd(plc_pkg::OFS_WATT_LOSS, 32'h0000_0000, "last watt loss");
    reg_rd(plc_pkg::OFS_STATUS, 32'h001D_0000, "status");
    final_report();
  end
endmodule // tb
